// file: rtl/hbcg_pkg.sv
// ****************************************************************
// host bus clock generation shared constants
// ****************************************************************
package hbcg_pkg;

    // register map (byte offsets on the plain register port)
    localparam logic [7:0]  HBCG_OUT_CTRL_ADDR = 8'h00;
    localparam logic [7:0]  HBCG_STATUS_ADDR   = 8'h04;
    localparam logic [7:0]  HBCG_RATIO_ADDR    = 8'h08;
    localparam logic [7:0]  HBCG_CFG_LOW_ADDR  = 8'h0C;
    localparam logic [7:0]  HBCG_CFG_HIGH_ADDR = 8'h10;

    // number of bus clock outputs
    localparam int          HBCG_NUM_OUT       = 3;
    localparam logic [2:0]  HBCG_OUT_CTRL_RST  = 3'h0;

    // reset configuration word field layout
    localparam int          HBCG_HOST_BIT      = 0;
    localparam int          HBCG_SYS_MULT_LSB  = 0;
    localparam int          HBCG_SYS_MULT_W    = 4;
    localparam int          HBCG_CORE_MULT_LSB = 4;
    localparam int          HBCG_CORE_MULT_W   = 4;
    localparam int          HBCG_RATIO_W       = 8;

    // hard-coded reset option words
    localparam logic [31:0] HBCG_HARD_CFG_LOW  = 32'h0000_0022;
    localparam logic [31:0] HBCG_HARD_CFG_HIGH = 32'h0000_0001;

    // status register field positions
    localparam int          HBCG_ST_HOST       = 0;
    localparam int          HBCG_ST_STRAP      = 1;
    localparam int          HBCG_ST_SYNC       = 2;
    localparam int          HBCG_ST_ACTIVE_LSB = 4;
    localparam int          HBCG_ST_PIN_LSB    = 8;
    localparam int          HBCG_ST_LOADED     = 12;

    // ratio register field positions
    localparam int          HBCG_RT_CSB_LSB    = 0;
    localparam int          HBCG_RT_CORE_LSB   = 8;

    // domain divisors
    localparam int          HBCG_CSB_DIV       = 1;
    localparam int          HBCG_COMMS_DIV     = 2;
    localparam int          HBCG_MEM_DIV       = 2;
    localparam int          HBCG_LBC_DIV       = 4;

endpackage : hbcg_pkg

// file: rtl/hbcg_tick_div.sv
`timescale 1ns/10ps
// ****************************************************************
// pulse divider: one output tick per DIV input pulses
// ****************************************************************
module hbcg_tick_div #(
    parameter int DIV = 2
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic in_pulse,
    output logic      tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          tick_reg;
    logic          tick_next;

    // count input pulses, wrap at the divisor
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (in_pulse) begin
            if (cnt_reg == LAST) begin
                cnt_next  = '0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // register state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : hbcg_tick_div

// file: rtl/hbcg_clock_gen.sv
`timescale 1ns/10ps
// Operation
// - host role bit set: reference clock input is the primary clock
// - strap picks sync clock output as reference unchanged or halved
// - host role drives three bus clock outputs, index zero to two
// - after reset all bus clock outputs disabled and driven low
// - each output toggles only once its own enable bit is set
// - enabled bus clock outputs stay phase-aligned with each other
// - agent role: incoming sync clock is primary, outputs unused
// - four internal domains derived from the primary clock
// - system bus ratio is one plus inverted strap times system multiplier
// - core ratio is system bus ratio times core multiplier
// - multipliers come from low config word, loaded at reset or hard option
module hbcg_clock_gen
    import hbcg_pkg::*;
#(
    parameter int NUM_OUT = HBCG_NUM_OUT
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        system_reference_clock_in,
    input  wire logic        bus_sync_clock_in,
    input  wire logic        input_divide_strap,
    input  wire logic [31:0] reset_config_word_high,
    input  wire logic [31:0] reset_config_word_low,
    input  wire logic        hard_reset_option_sel,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic [NUM_OUT-1:0] bus_clock_out,
    output logic             bus_sync_clock_out,
    output logic             system_bus_tick,
    output logic             comms_engine_tick,
    output logic             memory_ctrl_tick,
    output logic             local_bus_tick,
    output logic [HBCG_RATIO_W-1:0] system_bus_ratio,
    output logic [HBCG_RATIO_W-1:0] core_ratio
);

    // ****************************************************************
    // configuration capture
    // ****************************************************************
    logic        loaded_reg;
    logic        loaded_next;
    logic [31:0] cfg_low_reg;
    logic [31:0] cfg_low_next;
    logic [31:0] cfg_high_reg;
    logic [31:0] cfg_high_next;
    logic        strap_reg;
    logic        strap_next;

    // words and strap latched on the first edge after reset release
    always_comb begin
        loaded_next   = 1'b1;
        cfg_low_next  = cfg_low_reg;
        cfg_high_next = cfg_high_reg;
        strap_next    = strap_reg;
        if (!loaded_reg) begin
            cfg_low_next  = hard_reset_option_sel ? HBCG_HARD_CFG_LOW : reset_config_word_low;
            cfg_high_next = hard_reset_option_sel ? HBCG_HARD_CFG_HIGH : reset_config_word_high;
            strap_next    = input_divide_strap;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            loaded_reg   <= 1'b0;
            cfg_low_reg  <= '0;
            cfg_high_reg <= '0;
            strap_reg    <= 1'b0;
        end else begin
            loaded_reg   <= loaded_next;
            cfg_low_reg  <= cfg_low_next;
            cfg_high_reg <= cfg_high_next;
            strap_reg    <= strap_next;
        end
    end

    logic                        host_role;
    logic [HBCG_SYS_MULT_W-1:0]  sys_mult;
    logic [HBCG_CORE_MULT_W-1:0] core_mult;
    assign host_role = loaded_reg & cfg_high_reg[HBCG_HOST_BIT];
    assign sys_mult  = cfg_low_reg[HBCG_SYS_MULT_LSB +: HBCG_SYS_MULT_W];
    assign core_mult = cfg_low_reg[HBCG_CORE_MULT_LSB +: HBCG_CORE_MULT_W];

    // ****************************************************************
    // primary clock selection and sync clock output
    // ****************************************************************
    logic ref_prev_reg;
    logic sin_prev_reg;
    logic ref_rise;
    logic sin_rise;
    logic primary_edge;
    logic sync_reg;
    logic sync_next;

    assign ref_rise     = system_reference_clock_in & ~ref_prev_reg;
    assign sin_rise     = bus_sync_clock_in & ~sin_prev_reg;
    // host follows the reference input, agent the incoming sync clock
    assign primary_edge = host_role ? ref_rise : (loaded_reg & sin_rise);

    // sync output: reference as is, or toggled on each reference rise
    always_comb begin
        sync_next = 1'b0;
        if (host_role) begin
            if (strap_reg)
                sync_next = system_reference_clock_in;
            else
                sync_next = sync_reg ^ ref_rise;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_prev_reg <= 1'b0;
            sin_prev_reg <= 1'b0;
            sync_reg     <= 1'b0;
        end else begin
            ref_prev_reg <= system_reference_clock_in;
            sin_prev_reg <= bus_sync_clock_in;
            sync_reg     <= sync_next;
        end
    end

    // ****************************************************************
    // output clock control and bus clock outputs
    // ****************************************************************
    logic [NUM_OUT-1:0] out_ctrl_reg;
    logic [NUM_OUT-1:0] out_ctrl_next;
    logic [NUM_OUT-1:0] active_reg;
    logic [NUM_OUT-1:0] active_next;
    logic [NUM_OUT-1:0] pin_reg;
    logic [NUM_OUT-1:0] pin_next;

    // software enables; live enables follow only while sync is low
    always_comb begin
        out_ctrl_next = out_ctrl_reg;
        active_next   = active_reg;
        if (reg_wr && reg_addr == HBCG_OUT_CTRL_ADDR)
            out_ctrl_next = reg_wdata[NUM_OUT-1:0];
        if (!host_role)
            active_next = '0;
        else if (!sync_reg)
            active_next = out_ctrl_reg;
    end

    // all pins gated from one sync register, so edges line up
    always_comb begin
        pin_next = active_next & {NUM_OUT{sync_next}};
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_ctrl_reg <= NUM_OUT'(HBCG_OUT_CTRL_RST);
            active_reg <= '0;
            pin_reg    <= '0;
        end else begin
            out_ctrl_reg <= out_ctrl_next;
            active_reg <= active_next;
            pin_reg    <= pin_next;
        end
    end

    assign bus_clock_out      = pin_reg;
    assign bus_sync_clock_out = sync_reg;

    // ****************************************************************
    // ratios and internal domain ticks
    // ****************************************************************
    logic [HBCG_RATIO_W-1:0] csb_ratio_reg;
    logic [HBCG_RATIO_W-1:0] csb_ratio_next;
    logic [HBCG_RATIO_W-1:0] core_ratio_reg;
    logic [HBCG_RATIO_W-1:0] core_ratio_next;
    logic [HBCG_RATIO_W-1:0] in_scale;

    // (1 + inverted strap) times system multiplier, then core multiplier
    always_comb begin
        in_scale        = strap_reg ? HBCG_RATIO_W'(1) : HBCG_RATIO_W'(2);
        csb_ratio_next  = HBCG_RATIO_W'(in_scale * HBCG_RATIO_W'(sys_mult));
        core_ratio_next = HBCG_RATIO_W'(csb_ratio_reg * HBCG_RATIO_W'(core_mult));
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            csb_ratio_reg  <= '0;
            core_ratio_reg <= '0;
        end else begin
            csb_ratio_reg  <= csb_ratio_next;
            core_ratio_reg <= core_ratio_next;
        end
    end

    assign system_bus_ratio = csb_ratio_reg;
    assign core_ratio       = core_ratio_reg;

    // four domains: bus ticks from primary edges, others from bus ticks
    hbcg_tick_div #(.DIV(HBCG_CSB_DIV)) u_csb (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .in_pulse (primary_edge),
        .tick     (system_bus_tick)
    );
    hbcg_tick_div #(.DIV(HBCG_COMMS_DIV)) u_comms (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .in_pulse (system_bus_tick),
        .tick     (comms_engine_tick)
    );
    hbcg_tick_div #(.DIV(HBCG_MEM_DIV)) u_mem (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .in_pulse (system_bus_tick),
        .tick     (memory_ctrl_tick)
    );
    hbcg_tick_div #(.DIV(HBCG_LBC_DIV)) u_lbc (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .in_pulse (system_bus_tick),
        .tick     (local_bus_tick)
    );

    // ****************************************************************
    // register read port
    // ****************************************************************
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // read data stands one cycle after the read strobe; unmapped reads zero
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                HBCG_OUT_CTRL_ADDR: rdata_next[NUM_OUT-1:0] = out_ctrl_reg;
                HBCG_STATUS_ADDR: begin
                    rdata_next[HBCG_ST_HOST]                    = host_role;
                    rdata_next[HBCG_ST_STRAP]                   = strap_reg;
                    rdata_next[HBCG_ST_SYNC]                    = sync_reg;
                    rdata_next[HBCG_ST_ACTIVE_LSB +: NUM_OUT]   = active_reg;
                    rdata_next[HBCG_ST_PIN_LSB +: NUM_OUT]      = pin_reg;
                    rdata_next[HBCG_ST_LOADED]                  = loaded_reg;
                end
                HBCG_RATIO_ADDR: begin
                    rdata_next[HBCG_RT_CSB_LSB +: HBCG_RATIO_W]  = csb_ratio_reg;
                    rdata_next[HBCG_RT_CORE_LSB +: HBCG_RATIO_W] = core_ratio_reg;
                end
                HBCG_CFG_LOW_ADDR: rdata_next = cfg_low_reg;
                HBCG_CFG_HIGH_ADDR: rdata_next = cfg_high_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata = rdata_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_sync_low;
        $past(!sync_reg);
    endsequence
    sequence s_enable_moved;
        active_reg != $past(active_reg);
    endsequence

    property p_host_source;
        host_role |=> (system_bus_tick == $past(ref_rise));
    endproperty
    a_host_source: assert property (p_host_source) else $error("host bus tick not from reference");

    property p_sync_plain;
        (host_role && strap_reg) |=> (sync_reg == $past(system_reference_clock_in));
    endproperty
    a_sync_plain: assert property (p_sync_plain) else $error("sync output not following reference");

    property p_sync_half;
        (host_role && !strap_reg && !ref_rise) |=> (sync_reg == $past(sync_reg));
    endproperty
    a_sync_half: assert property (p_sync_half) else $error("halved sync moved without reference rise");

    property p_phase_aligned;
        ((active_reg & {NUM_OUT{|pin_reg}}) ^ pin_reg) == '0;
    endproperty
    a_phase_aligned: assert property (p_phase_aligned) else $error("live bus clocks not in step");

    property p_gated_by_enable;
        ((pin_reg & ~$past(pin_reg)) & ~$past(out_ctrl_reg)) == '0;
    endproperty
    a_gated_by_enable: assert property (p_gated_by_enable) else $error("bus clock toggling while disabled");

    property p_clean_change;
        s_enable_moved |-> s_sync_low;
    endproperty
    a_clean_change: assert property (p_clean_change) else $error("enable changed while sync high");

    property p_agent_quiet;
        (loaded_reg && !host_role) |=> (bus_clock_out == '0 && !bus_sync_clock_out);
    endproperty
    a_agent_quiet: assert property (p_agent_quiet) else $error("agent role drives clock outputs");

    property p_reset_low;
        !loaded_reg |-> (bus_clock_out == '0 && active_reg == '0);
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("bus clock not low after reset");

    property p_csb_ratio;
        loaded_reg ##1 loaded_reg |-> csb_ratio_reg ==
            HBCG_RATIO_W'((strap_reg ? 1 : 2) * sys_mult);
    endproperty
    a_csb_ratio: assert property (p_csb_ratio) else $error("system bus ratio wrong");

    property p_core_ratio;
        loaded_reg ##2 1 |-> core_ratio_reg == HBCG_RATIO_W'(csb_ratio_reg * core_mult);
    endproperty
    a_core_ratio: assert property (p_core_ratio) else $error("core ratio wrong");

    property p_words_held;
        loaded_reg |=> ($stable(cfg_low_reg) && $stable(cfg_high_reg));
    endproperty
    a_words_held: assert property (p_words_held) else $error("config words changed after load");

    property p_domain_from_bus;
        comms_engine_tick |-> $past(system_bus_tick);
    endproperty
    a_domain_from_bus: assert property (p_domain_from_bus) else $error("comms tick without bus tick");

endmodule : hbcg_clock_gen

// file: verif/hbcg_agent_model.sv
`timescale 1ns/10ps
// ****************************************************************
// far side: board clock source and three bus agents
// ****************************************************************
module hbcg_agent_model #(
    parameter int HALF = 2
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        run_ref,
    input  wire logic        run_sync,
    input  wire logic [2:0]  bus_clock_out,
    output logic             ref_lvl,
    output logic             sync_lvl,
    output logic [15:0]      rise_cnt [3]
);
    int         ref_cnt;
    int         sync_cnt;
    logic [2:0] prev_bco;

    // oscillators stand still at low outside a run
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_lvl  <= 1'b0;
            sync_lvl <= 1'b0;
            ref_cnt  <= 0;
            sync_cnt <= 0;
        end else begin
            ref_cnt  <= (run_ref && ref_cnt != HALF - 1) ? ref_cnt + 1 : 0;
            sync_cnt <= (run_sync && sync_cnt != HALF - 1) ? sync_cnt + 1 : 0;
            ref_lvl  <= run_ref && (ref_cnt == HALF - 1 ? !ref_lvl : ref_lvl);
            sync_lvl <= run_sync && (sync_cnt == HALF - 1 ? !sync_lvl : sync_lvl);
        end
    end

    // each agent counts the rising edges of its own clock
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_bco <= 3'h0;
            for (int i = 0; i < 3; i++) rise_cnt[i] <= 16'h0;
        end else begin
            prev_bco <= bus_clock_out;
            for (int i = 0; i < 3; i++) begin
                if (bus_clock_out[i] && !prev_bco[i]) rise_cnt[i] <= rise_cnt[i] + 16'h1;
            end
        end
    end
endmodule : hbcg_agent_model

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
    import hbcg_pkg::*;

    localparam int HALF = 2;

    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        strap   = 1'b1;
    logic [31:0] cfg_hi  = 32'h0;
    logic [31:0] cfg_lo  = 32'h0;
    logic        hard    = 1'b0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr  = 1'b0;
    logic        reg_rd  = 1'b0;
    logic        run_ref = 1'b0;
    logic        run_sync = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0]  bco;
    logic        sync_out;
    logic        ref_lvl;
    logic        sync_lvl;
    logic        t_sys, t_comms, t_mem, t_lbc;
    logic [7:0]  sys_ratio;
    logic [7:0]  core_ratio;
    logic [15:0] rise_cnt [3];
    logic [2:0]  prev_bco = 3'h0;
    logic        prev_sync = 1'b0;
    int          err_count = 0;
    int          check_count = 0;
    int          glitch = 0;
    int          n_sync, n_sys, n_comms, n_mem, n_lbc;
    logic [31:0] rd;

    always #50 ref_clk = ~ref_clk;

    hbcg_clock_gen u_dut (
        .ref_clk                   (ref_clk),
        .reset_n                   (reset_n),
        .system_reference_clock_in (ref_lvl),
        .bus_sync_clock_in         (sync_lvl),
        .input_divide_strap        (strap),
        .reset_config_word_high    (cfg_hi),
        .reset_config_word_low     (cfg_lo),
        .hard_reset_option_sel     (hard),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_rdata                 (reg_rdata),
        .bus_clock_out             (bco),
        .bus_sync_clock_out        (sync_out),
        .system_bus_tick           (t_sys),
        .comms_engine_tick         (t_comms),
        .memory_ctrl_tick          (t_mem),
        .local_bus_tick            (t_lbc),
        .system_bus_ratio          (sys_ratio),
        .core_ratio                (core_ratio)
    );

    hbcg_agent_model #(.HALF(HALF)) u_far (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .run_ref       (run_ref),
        .run_sync      (run_sync),
        .bus_clock_out (bco),
        .ref_lvl       (ref_lvl),
        .sync_lvl      (sync_lvl),
        .rise_cnt      (rise_cnt)
    );

    // ****************************************************************
    // edge monitors: bus clocks may only move with the sync clock
    // ****************************************************************
    always @(negedge ref_clk) begin // mid-cycle, outputs settled
        if (reset_n) begin
            for (int i = 0; i < 3; i++) begin
                if (bco[i] && !sync_out) glitch++;
                if (bco[i] && !prev_bco[i] && !(sync_out && !prev_sync)) glitch++;
                if (!bco[i] && prev_bco[i] && !(!sync_out && prev_sync)) glitch++;
            end
            if (sync_out && !prev_sync) n_sync++;
            n_sys   += t_sys;
            n_comms += t_comms;
            n_mem   += t_mem;
            n_lbc   += t_lbc;
        end
        prev_bco  = bco;
        prev_sync = sync_out;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset(input logic s, input logic [31:0] hi, input logic [31:0] lo, input logic h);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        strap   <= s;
        cfg_hi  <= hi;
        cfg_lo  <= lo;
        hard    <= h;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        n_sync = 0; n_sys = 0; n_comms = 0; n_mem = 0; n_lbc = 0;
        repeat (5) @(posedge ref_clk);
    endtask : do_reset

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : reg_read

    // runs one oscillator for whole periods, then lets the pipeline drain
    task automatic run_clk(input logic use_sync, input int periods);
        @(posedge ref_clk);
        if (use_sync) run_sync <= 1'b1;
        else run_ref <= 1'b1;
        repeat (periods * 2 * HALF) @(posedge ref_clk);
        run_sync <= 1'b0;
        run_ref  <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : run_clk

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_host_undivided();
        do_reset(1'b1, 32'h1, 32'h53, 1'b0);
        reg_read(HBCG_STATUS_ADDR, rd);
        check("status host", {31'h0, rd[HBCG_ST_HOST]}, 32'h1);
        check("system ratio", {24'h0, sys_ratio}, 32'h3);
        check("core ratio", {24'h0, core_ratio}, 32'hF);
        run_clk(1'b0, 4);
        check("idle out0", {16'h0, rise_cnt[0]}, 32'h0);
        check("idle pins", {29'h0, bco}, 32'h0);
        check("host ticks", n_sys, 32'h4);
        reg_write(HBCG_OUT_CTRL_ADDR, 32'h1);
        reg_read(HBCG_OUT_CTRL_ADDR, rd);
        check("output control", rd, 32'h1);
        run_clk(1'b0, 8);
        check("out0 rises", {16'h0, rise_cnt[0]}, 32'h8);
        check("out1 rises", {16'h0, rise_cnt[1]}, 32'h0);
        check("sync rises", n_sync, 32'hC);
        reg_write(HBCG_OUT_CTRL_ADDR, 32'h7);
        run_clk(1'b0, 8);
        check("out0 rises", {16'h0, rise_cnt[0]}, 32'h10);
        check("out2 rises", {16'h0, rise_cnt[2]}, 32'h8);
        reg_write(HBCG_OUT_CTRL_ADDR, 32'h0);
        run_clk(1'b0, 4);
        check("off out1", {16'h0, rise_cnt[1]}, 32'h8);
        $display("test host_undivided done");
    endtask : test_host_undivided

    task automatic test_host_halved();
        do_reset(1'b0, 32'h1, 32'h53, 1'b0);
        reg_read(HBCG_RATIO_ADDR, rd);
        check("ratio reg", rd, 32'h1E06);
        reg_write(HBCG_OUT_CTRL_ADDR, 32'h7);
        run_clk(1'b0, 8);
        check("sync rises", n_sync, 32'h4);
        check("out1 rises", {16'h0, rise_cnt[1]}, 32'h4);
        // disable two outputs while the halved sync is high: the pulse in flight completes
        run_ref <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reg_write(HBCG_OUT_CTRL_ADDR, 32'h2);
        repeat (28) @(posedge ref_clk);
        run_ref <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check("late out0", {16'h0, rise_cnt[0]}, 32'h5);
        check("late out1", {16'h0, rise_cnt[1]}, 32'h8);
        $display("test host_halved done");
    endtask : test_host_halved

    task automatic test_hard_option();
        do_reset(1'b1, 32'h0, 32'h0, 1'b1);
        check("system ratio", {24'h0, sys_ratio}, 32'h2);
        check("core ratio", {24'h0, core_ratio}, 32'h4);
        reg_read(HBCG_CFG_LOW_ADDR, rd);
        check("low word", rd, HBCG_HARD_CFG_LOW);
        reg_read(HBCG_STATUS_ADDR, rd);
        check("status host", {31'h0, rd[HBCG_ST_HOST]}, 32'h1);
        $display("test hard_option done");
    endtask : test_hard_option

    task automatic test_agent();
        do_reset(1'b1, 32'h0, 32'h11, 1'b0);
        reg_write(HBCG_OUT_CTRL_ADDR, 32'h7);
        reg_write(HBCG_RATIO_ADDR, 32'hFFFF);
        reg_read(HBCG_RATIO_ADDR, rd);
        check("ratio read only", rd, 32'h0101);
        reg_read(8'h20, rd);
        check("unmapped read", rd, 32'h0);
        run_clk(1'b1, 8);
        check("system ticks", n_sys, 32'h8);
        check("comms ticks", n_comms, 32'h4);
        check("memory ticks", n_mem, 32'h4);
        check("local bus ticks", n_lbc, 32'h2);
        check("agent out0", {16'h0, rise_cnt[0]}, 32'h0);
        check("agent sync out", n_sync, 32'h0);
        reg_read(HBCG_STATUS_ADDR, rd);
        check("agent status", rd, 32'h0000_1002);
        $display("test agent done");
    endtask : test_agent

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        test_host_undivided();
        test_host_halved();
        test_hard_option();
        test_agent();
        check("edge alignment", glitch, 32'h0);
        complete_run();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(5000 * 100);
        err_count++;
        complete_run();
    end
endmodule : tb
